//--- core/bec_fifo.sv
// Purpose: synchronous valid/ready fifo
// Assumes: one clock, asynchronous active-low reset
// Notes:   rd_data is valid whenever rd_valid is high
`timescale 1ns/1ps
module bec_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign wr_ready = (cnt_q != (AW+1)'(D));
    assign rd_valid = (cnt_q != '0);
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;
    assign rd_data  = mem[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
            rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
            cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule

//--- core/bec_pkg.sv
// Purpose: shared constants of the beam evaluation stage
// Assumes: 25 MHz hclk, 32-bit AHB-Lite register bus
// Notes:   register offsets are word indices; byte address is index times four
package bec_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NBEAM      = 256;
    localparam int WORD_W     = 16;
    localparam int NWORDS     = NBEAM / WORD_W;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  GEN_IDX   = 8'h47;
    localparam logic [7:0]  EXT_IDX   = 8'h4a;
    localparam logic [7:0]  LOCK_IDX  = 8'h4e;
    localparam logic [7:0]  STAT_IDX  = 8'h50;
    localparam logic [11:0] GEN_ADDR  = {2'h0, GEN_IDX, 2'h0};
    localparam logic [11:0] EXT_ADDR  = {2'h0, EXT_IDX, 2'h0};
    localparam logic [11:0] LOCK_ADDR = {2'h0, LOCK_IDX, 2'h0};
    localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int MODE_LSB   = 24;
    localparam int DIR_LSB    = 16;
    localparam int SMOOTH_LSB = 8;
    localparam int GAP_LSB    = 0;
    localparam int DEPTH_LSB  = 16;
    localparam int ITIME_LSB  = 0;
    localparam int ST_REJ     = 0;
    localparam int ST_OVR     = 1;
    localparam int ST_BUSY    = 2;

    localparam logic [7:0]  MODE_PAR   = 8'h00;
    localparam logic [7:0]  MODE_DIAG  = 8'h01;
    localparam logic [7:0]  MODE_CROSS = 8'h02;
    localparam logic [7:0]  DIR_MAX    = 8'h01;
    localparam logic [7:0]  LOCK_MAX   = 8'h01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SMOOTH_RST = 8'h01;
    localparam logic [7:0]  GAP_RST    = 8'h01;
    localparam logic [7:0]  DEPTH_RST  = 8'h01;
    localparam logic [15:0] ITIME_RST  = 16'h0000;
    localparam logic [31:0] GEN_RST    = {MODE_PAR, 8'h00, SMOOTH_RST, GAP_RST};
    localparam logic [31:0] EXT_RST    = {8'h00, DEPTH_RST, ITIME_RST};
    localparam logic [7:0]  LOCK_RST   = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
endpackage

//--- core/bec_top.sv
// Purpose: beam evaluation stage with AHB-Lite settings and beam-bit stream
// Assumes: beam_raw and beam_strobe stable around the strobe edge
// Notes:   one evaluation at a time; strobes during a pass are counted as overrun
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module bec_top #(
    parameter int unsigned CYC_PER_MS = bec_pkg::CYC_PER_MS
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    input  wire logic [255:0] beam_raw,
    input  wire logic         beam_strobe,
    input  wire logic [1:0]   button_raw,
    output logic [1:0]        button_evt,
    output logic              panel_locked,
    output logic [15:0]       pd_data,
    output logic              pd_valid,
    input  wire logic         pd_ready,
    output logic              eval_busy
);
    typedef enum logic [2:0] {IDLE, WALK_OBJ, WALK_GAP, FILT, HOLD, OUT} bec_state_e;

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------
    logic [31:0] gen_q;
    logic [31:0] gen_d;
    logic [31:0] ext_q;
    logic [31:0] ext_d;
    logic [7:0]  lock_q;
    logic [7:0]  lock_d;
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic        ready_q;
    logic        rej_q;
    logic        rej_d;
    logic        ovr_q;
    logic        ovr_d;
    logic [15:0] ms_q;
    logic [7:0]  cons_q;
    bec_state_e  state_q;

    wire         addr_ph  = hsel && htrans[1] && hready;
    wire         wr_gen   = wr_pend_q && (wr_addr_q == bec_pkg::GEN_ADDR);
    wire         wr_ext   = wr_pend_q && (wr_addr_q == bec_pkg::EXT_ADDR);
    wire         wr_lock  = wr_pend_q && (wr_addr_q == bec_pkg::LOCK_ADDR);
    wire         wr_stat  = wr_pend_q && (wr_addr_q == bec_pkg::STAT_ADDR);
    wire [7:0]   w_mode   = hwdata[bec_pkg::MODE_LSB +: 8];
    wire [7:0]   w_dir    = hwdata[bec_pkg::DIR_LSB +: 8];
    wire [7:0]   w_smooth = hwdata[bec_pkg::SMOOTH_LSB +: 8];
    wire [7:0]   w_gap    = hwdata[bec_pkg::GAP_LSB +: 8];
    wire [7:0]   w_depth  = hwdata[bec_pkg::DEPTH_LSB +: 8];
    // a record is taken whole or not at all, so fields never mix old and new
    wire         gen_ok   = (w_mode <= bec_pkg::MODE_CROSS) && (w_dir <= bec_pkg::DIR_MAX)
                            && (w_smooth != 8'h00) && (w_gap != 8'h00);
    wire         ext_ok   = (w_depth != 8'h00);
    wire         lock_ok  = (hwdata[7:0] <= bec_pkg::LOCK_MAX);
    wire         rej_set  = (wr_gen && !gen_ok) || (wr_ext && !ext_ok) || (wr_lock && !lock_ok);
    wire         ovr_set;

    assign gen_d  = (wr_gen && gen_ok) ? hwdata : gen_q;
    assign ext_d  = (wr_ext && ext_ok) ? {8'h00, hwdata[23:0]} : ext_q;
    assign lock_d = (wr_lock && lock_ok) ? hwdata[7:0] : lock_q;
    // hardware set wins over a write-one clear in the same cycle
    assign rej_d  = rej_set || (rej_q && !(wr_stat && hwdata[bec_pkg::ST_REJ]));
    assign ovr_d  = ovr_set || (ovr_q && !(wr_stat && hwdata[bec_pkg::ST_OVR]));

    wire [31:0] stat_val = {ms_q, cons_q, 5'h00, (state_q != IDLE), ovr_d, rej_d};
    // reads use next values so a read right behind a write sees the new data
    wire [11:0] ra       = haddr[11:0];
    wire [31:0] rd_val   = (ra == bec_pkg::GEN_ADDR)  ? gen_d :
                           (ra == bec_pkg::EXT_ADDR)  ? ext_d :
                           (ra == bec_pkg::LOCK_ADDR) ? {24'h000000, lock_d} :
                           (ra == bec_pkg::STAT_ADDR) ? stat_val : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            hrdata_q  <= 32'h00000000;
            ready_q   <= 1'b0;
        end else begin
            ready_q   <= 1'b1;
            wr_pend_q <= addr_ph && hwrite;
            wr_addr_q <= haddr[11:0];
            hrdata_q  <= (addr_ph && !hwrite) ? rd_val : hrdata_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_q  <= bec_pkg::GEN_RST;
            ext_q  <= bec_pkg::EXT_RST;
            lock_q <= bec_pkg::LOCK_RST;
            rej_q  <= 1'b0;
            ovr_q  <= 1'b0;
        end else begin
            gen_q  <= gen_d;
            ext_q  <= ext_d;
            lock_q <= lock_d;
            rej_q  <= rej_d;
            ovr_q  <= ovr_d;
        end
    end

    wire [7:0]  cfg_mode   = gen_q[bec_pkg::MODE_LSB +: 8];
    wire        cfg_rev    = gen_q[bec_pkg::DIR_LSB];
    wire [7:0]  cfg_smooth = gen_q[bec_pkg::SMOOTH_LSB +: 8];
    wire [7:0]  cfg_gap    = gen_q[bec_pkg::GAP_LSB +: 8];
    wire [7:0]  cfg_depth  = ext_q[bec_pkg::DEPTH_LSB +: 8];
    wire [15:0] cfg_itime  = ext_q[bec_pkg::ITIME_LSB +: 16];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [255:0] beam_s1_q;
    logic [255:0] beam_s2_q;
    logic [2:0]   strb_q;
    logic [1:0]   btn_s1_q;
    logic [1:0]   btn_s2_q;
    logic [1:0]   btn_evt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            beam_s1_q <= '0;
            beam_s2_q <= '0;
            strb_q    <= 3'h0;
            btn_s1_q  <= 2'h0;
            btn_s2_q  <= 2'h0;
            btn_evt_q <= 2'h0;
        end else begin
            beam_s1_q <= beam_raw;
            beam_s2_q <= beam_s1_q;
            strb_q    <= {strb_q[1:0], beam_strobe};
            btn_s1_q  <= button_raw;
            btn_s2_q  <= btn_s1_q;
            btn_evt_q <= lock_q[0] ? 2'h0 : btn_s2_q;
        end
    end

    wire strobe_rise = strb_q[1] && !strb_q[2];
    wire capture     = strobe_rise && (state_q == IDLE);
    assign ovr_set   = strobe_rise && (state_q != IDLE);

    // ------------------------------------------------------------
    // beam ordering and scanning mode
    // ------------------------------------------------------------
    logic [255:0] nb;
    logic [255:0] ordered;

    // diagonal reads a beam or its neighbour, crossed needs both
    for (genvar j = 0; j < bec_pkg::NBEAM; j++) begin : g_order
        assign nb[j] = cfg_rev ? beam_s2_q[bec_pkg::NBEAM-1-j] : beam_s2_q[j];
        if (j < bec_pkg::NBEAM-1) begin : g_pair
            assign ordered[j] = (cfg_mode == bec_pkg::MODE_DIAG)  ? (nb[j] | nb[j+1]) :
                                (cfg_mode == bec_pkg::MODE_CROSS) ? (nb[j] & nb[j+1]) :
                                nb[j];
        end else begin : g_last
            assign ordered[j] = nb[j];
        end
    end

    // ------------------------------------------------------------
    // run-length smoothing, one beam per cycle
    // ------------------------------------------------------------
    logic [255:0] work_q;
    logic [255:0] work_d;
    logic [255:0] mask;
    logic [7:0]   idx_q;
    logic [7:0]   start_q;
    logic [8:0]   len_q;

    wire        walking  = (state_q == WALK_OBJ) || (state_q == WALK_GAP);
    wire        tgt      = (state_q == WALK_OBJ);
    wire        hit      = (work_q[idx_q] == tgt);
    wire        last     = (idx_q == 8'hff);
    wire [8:0]  cur_len  = hit ? 9'(len_q + 9'h001) : len_q;
    wire [7:0]  rstart   = (hit && len_q == 9'h000) ? idx_q : start_q;
    wire [7:0]  thr      = tgt ? cfg_smooth : cfg_gap;
    wire        end_run  = walking && (!hit || last);
    wire        kill     = end_run && (cur_len != 9'h000) && (cur_len < {1'b0, thr});
    wire [9:0]  rend     = 10'({2'h0, rstart} + {1'b0, cur_len});

    for (genvar j = 0; j < bec_pkg::NBEAM; j++) begin : g_mask
        assign mask[j] = kill && (10'(j) >= {2'h0, rstart}) && (10'(j) < rend);
    end

    assign work_d = capture ? ordered :
                    (kill && tgt)  ? (work_q & ~mask) :
                    kill           ? (work_q | mask) :
                    work_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_q  <= '0;
            idx_q   <= 8'h00;
            start_q <= 8'h00;
            len_q   <= 9'h000;
        end else begin
            work_q  <= work_d;
            idx_q   <= walking ? 8'(idx_q + 8'h01) : 8'h00;
            start_q <= rstart;
            len_q   <= (walking && !end_run) ? cur_len : 9'h000;
        end
    end

    // ------------------------------------------------------------
    // consistency filter and hold
    // ------------------------------------------------------------
    logic [255:0] prev_q;
    logic [255:0] eval_q;
    logic [255:0] acc_q;
    logic [255:0] hold_q;
    logic [15:0]  tick_q;
    logic [3:0]   widx_q;

    wire       same     = (work_q == prev_q);
    wire [7:0] cons_d   = !same ? 8'h01 : (cons_q == 8'hff) ? cons_q : 8'(cons_q + 8'h01);
    wire       eval_upd = (state_q == FILT) && (cons_d >= cfg_depth);
    wire       ms_tick  = (tick_q == 16'(CYC_PER_MS - 1));
    wire       win_done = (cfg_itime == 16'h0000) || (ms_q >= cfg_itime);
    wire       publish  = (state_q == HOLD) && win_done;
    wire       fifo_wr_ready;
    wire       push     = (state_q == OUT) && fifo_wr_ready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= '0;
            cons_q <= 8'h00;
            eval_q <= '0;
        end else if (state_q == FILT) begin
            prev_q <= work_q;
            cons_q <= cons_d;
            eval_q <= eval_upd ? work_q : eval_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q  <= '0;
            hold_q <= '0;
        end else if (state_q == HOLD) begin
            acc_q  <= publish ? '0 : (acc_q | eval_q);
            hold_q <= publish ? (acc_q | eval_q) : hold_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 16'h0000;
            ms_q   <= 16'h0000;
        end else begin
            tick_q <= (ms_tick || publish) ? 16'h0000 : 16'(tick_q + 16'h0001);
            ms_q   <= publish ? 16'h0000 :
                      (ms_tick && ms_q != 16'hffff) ? 16'(ms_q + 16'h0001) : ms_q;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    bec_state_e state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE:     state_d = capture ? WALK_OBJ : IDLE;
            WALK_OBJ: state_d = last ? WALK_GAP : WALK_OBJ;
            WALK_GAP: state_d = last ? FILT : WALK_GAP;
            FILT:     state_d = HOLD;
            HOLD:     state_d = publish ? OUT : IDLE;
            OUT:      state_d = (push && widx_q == 4'hf) ? IDLE : OUT;
            default:  state_d = IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= IDLE;
            widx_q  <= 4'h0;
        end else begin
            state_q <= state_d;
            widx_q  <= push ? 4'(widx_q + 4'h1) : (state_q == OUT ? widx_q : 4'h0);
        end
    end

    // ------------------------------------------------------------
    // beam-bit stream, word 0 carries beams 15..0, or beams 240..255 with reversed direction
    // ------------------------------------------------------------
    wire [15:0] fifo_wdata = hold_q[{widx_q, 4'h0} +: bec_pkg::WORD_W];
    wire        fifo_rvalid;
    wire [15:0] fifo_rdata;
    logic       pd_valid_q;
    logic [15:0] pd_data_q;
    logic       busy_q;
    wire        out_free   = !pd_valid_q || pd_ready;
    wire        take       = fifo_rvalid && out_free;

    bec_fifo #(
        .W (bec_pkg::WORD_W),
        .D (bec_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (hclk),
        .rst_n    (hresetn),
        .wr_valid (state_q == OUT),
        .wr_ready (fifo_wr_ready),
        .wr_data  (fifo_wdata),
        .rd_valid (fifo_rvalid),
        .rd_ready (out_free),
        .rd_data  (fifo_rdata)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_valid_q <= 1'b0;
            pd_data_q  <= 16'h0000;
            busy_q     <= 1'b0;
        end else begin
            pd_valid_q <= take || (pd_valid_q && !pd_ready);
            pd_data_q  <= take ? fifo_rdata : pd_data_q;
            busy_q     <= (state_d != IDLE);
        end
    end

    assign hrdata       = hrdata_q;
    assign hreadyout    = ready_q;
    assign hresp        = 1'b0;
    assign button_evt   = btn_evt_q;
    assign panel_locked = lock_q[0];
    assign pd_data      = pd_data_q;
    assign pd_valid     = pd_valid_q;
    assign eval_busy    = busy_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_mode_range;
        @(posedge hclk) disable iff (!hresetn) cfg_mode <= bec_pkg::MODE_CROSS;
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("beam mode out of range");

    property p_dir_order;
        @(posedge hclk) disable iff (!hresetn)
            (cfg_rev && cfg_mode == bec_pkg::MODE_PAR && capture) |=> (work_q[0] == $past(beam_s2_q[255]));
    endproperty
    a_dir_order: assert property (p_dir_order) else $error("reverse order wrong");

    property p_obj_kill;
        @(posedge hclk) disable iff (!hresetn)
            (state_q == WALK_OBJ && kill) |=> (work_q[$past(rstart)] == 1'b0);
    endproperty
    a_obj_kill: assert property (p_obj_kill) else $error("short object not removed");

    property p_gap_fill;
        @(posedge hclk) disable iff (!hresetn)
            (state_q == WALK_GAP && kill) |=> (work_q[$past(rstart)] == 1'b1);
    endproperty
    a_gap_fill: assert property (p_gap_fill) else $error("short gap not filled");

    property p_depth;
        @(posedge hclk) disable iff (!hresetn)
            (state_q == FILT && eval_q != work_q) ##1 (eval_q != $past(eval_q)) |-> (cons_q >= cfg_depth);
    endproperty
    a_depth: assert property (p_depth) else $error("result taken before filter depth");

    property p_no_hold;
        @(posedge hclk) disable iff (!hresetn)
            (state_q == HOLD && cfg_itime == 16'h0000) |=> (state_q == OUT) && (hold_q == $past(acc_q | eval_q));
    endproperty
    a_no_hold: assert property (p_no_hold) else $error("zero hold did not publish");

    property p_lock;
        @(posedge hclk) disable iff (!hresetn) lock_q[0] |=> (button_evt == 2'h0);
    endproperty
    a_lock: assert property (p_lock) else $error("button passed while locked");

    property p_stream_hold;
        @(posedge hclk) disable iff (!hresetn) (pd_valid && !pd_ready) |=> pd_valid && $stable(pd_data);
    endproperty
    a_stream_hold: assert property (p_stream_hold) else $error("stream word dropped");

    property p_sixteen;
        @(posedge hclk) disable iff (!hresetn) (push && widx_q == 4'hf) |=> (state_q == IDLE);
    endproperty
    a_sixteen: assert property (p_sixteen) else $error("frame not ended after 16 words");

    property p_reject;
        @(posedge hclk) disable iff (!hresetn) (wr_gen && !gen_ok) |=> $stable(gen_q) && rej_q;
    endproperty
    a_reject: assert property (p_reject) else $error("bad settings write taken");
endmodule

//--- dv/bec_sink.sv
// Purpose: fieldbus-side sink that collects the beam-bit stream
// Assumes: same clock as the stage
// Notes:   slow drops ready for two of every four cycles
`timescale 1ns/1ps
module bec_sink (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        slow,
    input  wire logic [15:0] pd_data,
    input  wire logic        pd_valid,
    output logic             pd_ready,
    output logic [15:0]      words [0:15],
    output int               n_words
);
    logic [1:0] ph_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q     <= 2'h0;
            pd_ready <= 1'b0;
            n_words  <= 0;
        end else begin
            ph_q     <= ph_q + 2'h1;
            pd_ready <= !slow || ph_q[1];
            // frame of 16 words, word k holds beams 16k+15..16k, or 240-16k..255-16k with reversed direction
            if (pd_valid && pd_ready) begin
                words[n_words[3:0]] <= pd_data;
                n_words             <= n_words + 1;
            end
        end
    end
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench of the beam evaluation stage
// Assumes: CYC_PER_MS shortened to 10
// Notes:   ahb master waits on hreadyout; the sink stalls the stream
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
    logic         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, beam_strobe = 0, slow = 0;
    logic         hreadyout, hresp, pd_valid, pd_ready, panel_locked, eval_busy;
    logic [31:0]  haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]   htrans = 0, button_raw = 0, button_evt;
    logic [2:0]   hsize = 3'h2;
    logic [255:0] beam_raw = 0;
    logic [15:0]  pd_data;
    logic [15:0]  words [0:15];
    int           n_words, err_total = 0, total_checks = 0;
    always #20 hclk = ~hclk;
    bec_top #(.CYC_PER_MS(10)) i_bec_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .beam_raw(beam_raw),
        .beam_strobe(beam_strobe), .button_raw(button_raw), .button_evt(button_evt),
        .panel_locked(panel_locked), .pd_data(pd_data), .pd_valid(pd_valid), .pd_ready(pd_ready),
        .eval_busy(eval_busy));
    bec_sink i_bec_sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .pd_data(pd_data),
        .pd_valid(pd_valid), .pd_ready(pd_ready), .words(words), .n_words(n_words));
    // ------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0, rd);
        `CHK(nm, e, rd)
        `CHK("okay", 1'b0, hresp)
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd_chk(bec_pkg::GEN_ADDR, bec_pkg::GEN_RST, "gen");
        rd_chk(bec_pkg::EXT_ADDR, bec_pkg::EXT_RST, "ext");
        rd_chk(bec_pkg::LOCK_ADDR, 32'h0, "lock");
        rd_chk(12'h200, 32'h0, "unmapped");
        for (int m = 2; m >= 0; m--) begin
            xfer(1'b1, bec_pkg::GEN_ADDR, {m[7:0], 24'h000101}, rd);
            rd_chk(bec_pkg::GEN_ADDR, {m[7:0], 24'h000101}, "mode");
        end
        xfer(1'b1, bec_pkg::EXT_ADDR, 32'h0003ffff, rd);
        rd_chk(bec_pkg::EXT_ADDR, 32'h0003ffff, "ext max");
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h03000101, rd);
        rd_chk(bec_pkg::GEN_ADDR, bec_pkg::GEN_RST, "bad mode");
        xfer(1'b1, bec_pkg::EXT_ADDR, 32'h00000000, rd);
        rd_chk(bec_pkg::EXT_ADDR, 32'h0003ffff, "bad depth");
        xfer(1'b0, bec_pkg::STAT_ADDR, 32'h0, rd);
        `CHK("reject flag", 1'b1, rd[0])
        xfer(1'b1, bec_pkg::STAT_ADDR, 32'h1, rd);
        xfer(1'b0, bec_pkg::STAT_ADDR, 32'h0, rd);
        `CHK("reject clear", 1'b0, rd[0])
        xfer(1'b1, bec_pkg::EXT_ADDR, bec_pkg::EXT_RST, rd);
        $display("test regs done");
    endtask
    task automatic t_panel;
        button_raw <= 2'h3;
        xfer(1'b1, bec_pkg::LOCK_ADDR, 32'h1, rd);
        repeat (6) @(posedge hclk);
        `CHK("locked", 1'b1, panel_locked)
        `CHK("buttons locked", 2'h0, button_evt)
        xfer(1'b1, bec_pkg::LOCK_ADDR, 32'h2, rd);
        rd_chk(bec_pkg::LOCK_ADDR, 32'h1, "lock range");
        xfer(1'b1, bec_pkg::LOCK_ADDR, 32'h0, rd);
        repeat (6) @(posedge hclk);
        `CHK("buttons free", 2'h3, button_evt)
        $display("test panel done");
    endtask
    // one pass; only word k may be non-zero
    task automatic pass_chk(input logic [255:0] v, input int k, input logic [15:0] e);
        int b;
        b = n_words + 16;
        beam_raw    <= v;
        beam_strobe <= 1'b1;
        repeat (8) @(posedge hclk);
        beam_strobe <= 1'b0;
        for (int i = 0; i < 3000 && n_words < b; i++) @(posedge hclk);
        @(posedge hclk);
        `CHK("frame words", b, n_words)
        for (int i = 0; i < 16; i++) `CHK("beam word", (i == k) ? e : 16'h0000, words[i])
        for (int i = 0; i < 200 && eval_busy !== 1'b0; i++) @(posedge hclk);
        `CHK("busy", 1'b0, eval_busy)
    endtask
    task automatic t_stream;
        slow <= 1'b1;
        pass_chk(256'h8, 0, 16'h0008);
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h00010101, rd);
        pass_chk(256'h8, 15, 16'h1000);
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h00000201, rd);
        pass_chk(256'h8, 0, 16'h0000);
        // beams 0 and 2 with a one-beam hole between them: the hole is filled
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h00000102, rd);
        pass_chk(256'h5, 0, 16'h0007);
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h01000101, rd);
        pass_chk(256'h8, 0, 16'h000c);
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h02000101, rd);
        pass_chk(256'h18, 0, 16'h0008);
        // depth 2: a new pattern shows only on its second consistent pass
        xfer(1'b1, bec_pkg::GEN_ADDR, 32'h00000101, rd);
        xfer(1'b1, bec_pkg::EXT_ADDR, 32'h00020000, rd);
        pass_chk(256'h20, 0, 16'h0008);
        pass_chk(256'h20, 0, 16'h0020);
        $display("test stream done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (15000) @(posedge hclk);
        err_total++;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_panel;
        t_stream;
        wrap_up;
    end
endmodule
